//--- hdl/dhp_host_port.sv
// Generic strobe host port with port-pin function routing
`timescale 1ns/1ps
`default_nettype none
module dhp_host_port
  import dhp_pkg::*;
#(
  parameter int IN_WIDTH  = IN_W,
  parameter int OUT_WIDTH = OUT_W
) (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // Processor strobes and select
  input  wire dhp_pkg::dhp_bus_type   bus,
  // Data bus, split into three signals
  input  wire logic [7:0]             data_in,
  output logic      [7:0]             data_out,
  output logic                        data_oe_n,
  // Parallel ports
  input  wire logic [IN_WIDTH-1:0]    in_port,
  output logic      [OUT_WIDTH-1:0]   out_port,
  output logic      [OUT_WIDTH-1:0]   out_port_oe_n,
  // Special functions from the core
  input  wire logic                   irq_pending,
  input  wire logic [OUT_WIDTH-1:0]   special_out,
  input  wire logic                   rx_b_data,
  // Interrupt request, open drain
  output logic                        irq_out,
  output logic                        irq_oe_n,
  // Routing and events toward the core
  output var dhp_pkg::dhp_route_type  route,
  output logic                        rx_b_bit_valid,
  output logic                        rx_b_bit,
  output logic                        ct_start,
  output logic                        ct_stop
);
  import dhp_pkg::*;

  // Settled strobes and inputs
  logic [2:0]          strb_s, strb_r, strb_f;
  logic [IN_WIDTH-1:0] in_s, in_r, in_f;
  logic                cs_n_s, rd_n_s, wr_n_s;
  logic                rd_act, wr_act;      // Both strobes low
  logic                rd_go, wr_go;        // One-cycle access events

  // Programmed storage
  logic [7:0] mode_a_reg, mode_b_reg;
  logic [7:0] csr_a_reg, chan_b_clock_sel_reg;
  logic [7:0] acr_reg, opcr_reg;
  logic [7:0] vector_holding_reg;
  logic [OUT_WIDTH-1:0] op_reg;
  logic [7:0] wdata_reg;               // Data held while write is open
  logic [3:0] sel_reg;                 // Select held while access is open
  logic       wr_open_reg;
  logic [IN_WIDTH-1:0] ipcr_reg;       // Changed bits since last read

  // Strobes are resynchronised; each edge becomes one pulse
  dhp_sync #(.W(3)) u_strb (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({bus.cs_n, bus.rd_n, bus.wr_n}),
    .rst_val (3'h7),
    .dout    (strb_s),
    .rise    (strb_r),
    .fall    (strb_f)
  );

  // Input pins share the same two-stage crossing
  dhp_sync #(.W(IN_WIDTH)) u_inp (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     (in_port),
    .rst_val ('1),
    .dout    (in_s),
    .rise    (in_r),
    .fall    (in_f)
  );

  assign cs_n_s = strb_s[2];
  assign rd_n_s = strb_s[1];
  assign wr_n_s = strb_s[0];
  assign rd_act = ~cs_n_s & ~rd_n_s;
  assign wr_act = ~cs_n_s & ~wr_n_s;
  // Read fires when the later of the two falls lands
  assign rd_go  = rd_act & (strb_f[2] | strb_f[1]);
  // Write fires on whichever strobe rises first while open
  assign wr_go  = wr_open_reg & (cs_n_s | wr_n_s);

  // Decides whether a select code on the write side is an output-port set or clear command
  function automatic logic is_cmd_wr(input logic [3:0] s);
    is_cmd_wr = (s == WR_OP_SET) || (s == WR_OP_CLR);
  endfunction

  // Hold select and data while the write window is open
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_open_reg <= 1'b0;
      wdata_reg   <= BYTE_RST;
      sel_reg     <= 4'h0;
    end else if (wr_go) begin
      wr_open_reg <= 1'b0;
    end else if (wr_act) begin
      // Latest stable value wins; host keeps lines steady across strobe
      wr_open_reg <= 1'b1;
      wdata_reg   <= data_in;
      sel_reg     <= bus.sel;
    end else if (rd_go) begin
      sel_reg     <= bus.sel;
    end
  end

  // Ordinary register stores, one per closed write
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      mode_a_reg           <= BYTE_RST;
      mode_b_reg           <= BYTE_RST;
      csr_a_reg            <= BYTE_RST;
      chan_b_clock_sel_reg <= BYTE_RST;
      acr_reg              <= BYTE_RST;
      opcr_reg             <= BYTE_RST;
      vector_holding_reg   <= VECTOR_RST;
    end else if (wr_go && !is_cmd_wr(sel_reg)) begin
      case (sel_reg)
        WR_MODE_A: mode_a_reg           <= wdata_reg;
        WR_MODE_B: mode_b_reg           <= wdata_reg;
        WR_CSR_A:  csr_a_reg            <= wdata_reg;
        WR_CSR_B:  chan_b_clock_sel_reg <= wdata_reg;
        WR_ACR:    acr_reg              <= wdata_reg;
        WR_OPCR:   opcr_reg             <= wdata_reg;
        WR_VECTOR: vector_holding_reg   <= wdata_reg;
        default:   ;                    // Unused write codes; nothing is stored
      endcase
    end
  end

  // Output port: set and reset by address-triggered commands
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      op_reg <= '0;
    end else if (wr_go && sel_reg == WR_OP_SET) begin
      op_reg <= op_reg | wdata_reg[OUT_WIDTH-1:0];
    end else if (wr_go && sel_reg == WR_OP_CLR) begin
      op_reg <= op_reg & ~wdata_reg[OUT_WIDTH-1:0];
    end
  end

  // Input change flags; a change in the read cycle survives the clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ipcr_reg <= '0;
    end else if (rd_go && bus.sel == RD_IPCR) begin
      ipcr_reg <= in_r | in_f;
    end else begin
      ipcr_reg <= ipcr_reg | in_r | in_f;
    end
  end

  // Read data and bus drive; only during an open read cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_out  <= BYTE_RST;
      data_oe_n <= 1'b1;
    end else if (!rd_act) begin
      data_oe_n <= 1'b1;
    end else if (rd_go) begin
      data_oe_n <= 1'b0;
      case (bus.sel)
        RD_MODE_A:  data_out <= mode_a_reg;
        RD_MODE_B:  data_out <= mode_b_reg;
        RD_CSR_A:   data_out <= csr_a_reg;
        RD_CSR_B:   data_out <= chan_b_clock_sel_reg;
        RD_IPCR:    data_out <= {1'b0, ipcr_reg};
        // Stored vector is only ever returned as data, never for a vector cycle
        RD_VECTOR:  data_out <= vector_holding_reg;
        RD_IN_PORT: data_out <= {1'b0, in_s};
        default:    data_out <= BYTE_RST;
      endcase
    end
  end

  // Counter start and stop commands are reads of their addresses
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ct_start <= 1'b0;
      ct_stop  <= 1'b0;
    end else begin
      ct_start <= rd_go && bus.sel == RD_CT_START;
      ct_stop  <= rd_go && bus.sel == RD_CT_STOP;
    end
  end

  // Input pin routing to dedicated clock functions
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      route <= '0;
    end else begin
      route.chan_b_rx_ext_clock <= in_s[6];
      // Only the channel B select field picks the external receive clock
      route.rx_b_ext_sel <=
        chan_b_clock_sel_reg[CSR_RX_HI:CSR_RX_LO] == CSR_RX_EXT;
      route.ct_ext_clock <= in_s[2];
      route.ct_ext_sel   <=
        acr_reg[ACR_CT_HI:ACR_CT_LO] == CT_SRC_IP2 ||
        acr_reg[ACR_CT_HI:ACR_CT_LO] == CNT_SRC_IP2;
    end
  end

  // Receiver B bit capture on each rising edge of its external clock
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rx_b_bit_valid <= 1'b0;
      rx_b_bit       <= 1'b1;
    end else begin
      rx_b_bit_valid <= route.rx_b_ext_sel & in_r[6];
      if (route.rx_b_ext_sel && in_r[6]) begin
        rx_b_bit <= rx_b_data;
      end
    end
  end

  // Output pins: plain push-pull, or open drain when special
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_port      <= '0;
      out_port_oe_n <= '0;
    end else begin
      for (int i = 0; i < OUT_WIDTH; i++) begin
        if (i >= OP_OD_LO && opcr_reg[i[2:0]]) begin
          // Special: only pulls low, pull-up gives the high level
          out_port[i]      <= 1'b0;
          out_port_oe_n[i] <= special_out[i];
        end else begin
          out_port[i]      <= op_reg[i];
          out_port_oe_n[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt pin pulls low only; no acknowledge input exists
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_out  <= 1'b0;
      irq_oe_n <= 1'b1;
    end else begin
      irq_out  <= 1'b0;
      irq_oe_n <= ~irq_pending;
    end
  end

  // Write only after both strobes were low together
  chk_write_needs_both: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go |-> $past(wr_act, 1) || $past(wr_open_reg, 1))
    else $error("write closed without an open window");

  // A write closes once and clears its window next cycle
  chk_write_once: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go |=> !wr_open_reg)
    else $error("write window not closed");

  // Store lands in the vector register one cycle after close
  chk_vector_store: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go && sel_reg == WR_VECTOR |=> vector_holding_reg == $past(wdata_reg))
    else $error("vector register not stored");

  // Data bus driven only during a read cycle
  chk_bus_drive: assert property (@(posedge clk_sys) disable iff (rst)
    !data_oe_n |-> $past(rd_act, 1))
    else $error("data bus driven outside read");

  // Read drive starts the cycle after the read event
  chk_read_start: assert property (@(posedge clk_sys) disable iff (rst)
    rd_go |=> !data_oe_n)
    else $error("read did not start");

  // Chip select alone moves no data
  chk_cs_alone: assert property (@(posedge clk_sys) disable iff (rst)
    !cs_n_s && rd_n_s && wr_n_s && !wr_open_reg |-> !wr_go && !rd_go)
    else $error("transfer with chip select alone");

  // Set command raises every written bit
  chk_op_set: assert property (@(posedge clk_sys) disable iff (rst)
    wr_go && sel_reg == WR_OP_SET |=> (op_reg & $past(wdata_reg)) == $past(wdata_reg))
    else $error("output set command lost");

  // Counter start pulse follows its read by one cycle
  chk_ct_start: assert property (@(posedge clk_sys) disable iff (rst)
    rd_go && bus.sel == RD_CT_START |=> ct_start ##1 !ct_start)
    else $error("counter start pulse wrong");

  // Interrupt pin never drives high
  chk_irq_od: assert property (@(posedge clk_sys) disable iff (rst)
    !irq_oe_n |-> !irq_out ##1 (irq_oe_n == !$past(irq_pending)))
    else $error("interrupt pin drove high");

  // Receiver B takes a bit on its clock rise when selected
  chk_rx_sample: assert property (@(posedge clk_sys) disable iff (rst)
    route.rx_b_ext_sel && in_r[6] |=> rx_b_bit_valid && rx_b_bit == $past(rx_b_data))
    else $error("receiver B sample missed");

  // Counter stop pulse follows its read by one cycle
  chk_ct_stop: assert property (@(posedge clk_sys) disable iff (rst)
    rd_go && bus.sel == RD_CT_STOP |=> ct_stop ##1 !ct_stop)
    else $error("counter stop pulse wrong");

  // Upper output bits in a special role never drive a high level
  chk_op_open_drain: assert property (@(posedge clk_sys) disable iff (rst)
    (out_port[OUT_WIDTH-1:OP_OD_LO] & $past(opcr_reg[OUT_WIDTH-1:OP_OD_LO])) == '0)
    else $error("special output drove high");

  // Reading the change flags keeps only changes of that same cycle
  chk_ipcr_clear: assert property (@(posedge clk_sys) disable iff (rst)
    rd_go && bus.sel == RD_IPCR |=> (ipcr_reg & ~$past(in_r | in_f)) == '0)
    else $error("change flags not cleared by read");

  // Data bus released the cycle after the read cycle ends
  chk_bus_release: assert property (@(posedge clk_sys) disable iff (rst)
    !rd_act |=> data_oe_n)
    else $error("data bus held after read");

endmodule // dhp_host_port
`default_nettype wire

//--- hdl/dhp_pkg.sv
// Package: constants and carrier types for the generic host port
package dhp_pkg;

  // Register select codes, read side
  localparam logic [3:0] RD_MODE_A    = 4'h0;
  localparam logic [3:0] RD_CSR_A     = 4'h2;
  localparam logic [3:0] RD_IPCR      = 4'h4;
  localparam logic [3:0] RD_MODE_B    = 4'h8;
  localparam logic [3:0] RD_CSR_B     = 4'ha;
  localparam logic [3:0] RD_VECTOR    = 4'hc;
  localparam logic [3:0] RD_IN_PORT   = 4'hd;
  localparam logic [3:0] RD_CT_START  = 4'he;
  localparam logic [3:0] RD_CT_STOP   = 4'hf;
  // Register select codes, write side
  localparam logic [3:0] WR_MODE_A    = 4'h0;
  localparam logic [3:0] WR_CSR_A     = 4'h1;
  localparam logic [3:0] WR_ACR       = 4'h4;
  localparam logic [3:0] WR_MODE_B    = 4'h8;
  localparam logic [3:0] WR_CSR_B     = 4'h9;
  localparam logic [3:0] WR_VECTOR    = 4'hc;
  localparam logic [3:0] WR_OPCR      = 4'hd;
  localparam logic [3:0] WR_OP_SET    = 4'he;
  localparam logic [3:0] WR_OP_CLR    = 4'hf;

  // Reset values
  localparam logic [7:0] VECTOR_RST   = 8'h0f;
  localparam logic [7:0] BYTE_RST     = 8'h00;

  // Field positions
  localparam int         CSR_RX_HI    = 7;
  localparam int         CSR_RX_LO    = 4;
  localparam logic [3:0] CSR_RX_EXT   = 4'hf;
  localparam int         ACR_CT_HI    = 6;
  localparam int         ACR_CT_LO    = 4;
  localparam logic [2:0] CT_SRC_IP2   = 3'h0;
  localparam logic [2:0] CNT_SRC_IP2  = 3'h4;
  localparam int         OP_OD_LO     = 3;

  // Widths
  localparam int         IN_W         = 7;
  localparam int         OUT_W        = 8;

  // Strobe group from the processor
  typedef struct packed {
    logic       cs_n;
    logic       rd_n;
    logic       wr_n;
    logic [3:0] sel;
  } dhp_bus_type;

  // Special-function routing seen by the rest of the chip
  typedef struct packed {
    logic chan_b_rx_ext_clock;
    logic rx_b_ext_sel;
    logic ct_ext_clock;
    logic ct_ext_sel;
  } dhp_route_type;

endpackage : dhp_pkg

//--- hdl/dhp_sync.sv
// Two-stage synchroniser with rise and fall pulses on the settled copy
`timescale 1ns/1ps
`default_nettype none
module dhp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst,
  // Raw level and its settled copy
  input  wire logic [W-1:0] din,
  input  wire logic [W-1:0] rst_val,
  output logic      [W-1:0] dout,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] fall
);
  logic [W-1:0] s1_reg;   // First stage, read only by the second
  logic [W-1:0] s2_reg;   // Settled level
  logic [W-1:0] s3_reg;   // Previous settled level for edges

  // Reset value preset is a constant at both instances
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      s1_reg <= '1;
      s2_reg <= '1;
      s3_reg <= '1;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  assign dout = s2_reg;
  assign rise = s2_reg & ~s3_reg;
  assign fall = ~s2_reg & s3_reg;
endmodule // dhp_sync
`default_nettype wire

//--- verif/dhp_cpu_model.sv
// Processor bus model: strobe read and write cycles toward the host port
`timescale 1ns/1ps
`default_nettype none
module dhp_cpu_model (
  // Clock
  input  wire logic               clk_sys,
  // Strobes, select and write data toward the port
  output var  dhp_pkg::dhp_bus_type bus,
  output logic [7:0]              data_in,
  // Read data back from the port
  input  wire logic [7:0]         data_out,
  input  wire logic               data_oe_n
);
  import dhp_pkg::*;

  localparam int HOLD = 6;  // Strobe span, kept above the three-cycle minimum

  // Idle bus at time zero
  initial begin
    bus     = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, sel: 4'h0};
    data_in = 8'h00;
  end

  // Gap between accesses; read and write never overlap
  task automatic gap();
    repeat (HOLD) @(negedge clk_sys);
  endtask

  // Write: mode 0 both, 1 select only, 2 strobe only, 3 select rises first
  task automatic wr(input logic [3:0] sel, input logic [7:0] d, input int mode);
    @(negedge clk_sys);
    bus.sel  = sel;
    data_in  = d;
    bus.cs_n = (mode == 2);
    bus.wr_n = (mode == 1);
    repeat (HOLD) @(negedge clk_sys);
    if (mode == 3) begin
      // Chip select ends the cycle ahead of the strobe
      bus.cs_n = 1'b1;
      repeat (2) @(negedge clk_sys);
    end
    bus.cs_n = 1'b1;
    bus.wr_n = 1'b1;
    gap();
    // Held data has run out; show the inverse so a late sample is caught
    data_in = ~d;
  endtask

  // Read: mode 0 both, 1 select falls last, 2 strobe only, 3 select only
  task automatic rd(input logic [3:0] sel, output logic [7:0] q, input int mode);
    @(negedge clk_sys);
    bus.sel = sel;
    if (mode == 1) begin
      // Strobe first, so the later select edge starts the read
      bus.rd_n = 1'b0;
      repeat (3) @(negedge clk_sys);
    end
    bus.cs_n = (mode == 2);
    bus.rd_n = (mode == 3);
    repeat (HOLD) @(negedge clk_sys);
    // An undriven bus reads as unknown; an unknown enable gives a wrong byte
    q = (data_oe_n === 1'b0) ? data_out : ((data_oe_n === 1'b1) ? 8'hxx : 8'hee);
    bus.cs_n = 1'b1;
    bus.rd_n = 1'b1;
    gap();
  endtask
endmodule // dhp_cpu_model
`default_nettype wire

//--- verif/duart_generic_host_port_tb_top.sv
// Self-checking testbench for the generic host port
`timescale 1ns/1ps
`default_nettype none
module duart_generic_host_port_tb_top;
  import dhp_pkg::*;

  logic        clk_sys;                // System clock
  logic        rst;                    // Reset, active high
  dhp_bus_type cpu_bus;                // Strobes from the model
  logic [7:0]  cpu_data;               // Model's drive of the data bus
  logic [7:0]  data_bus;               // Resolved data bus
  logic [7:0]  data_out;               // Port read data
  logic        data_oe_n;              // Port bus enable
  logic [6:0]  in_port;                // Input port pins
  logic [7:0]  out_port;               // Output port pins
  logic [7:0]  out_port_oe_n;          // Output port enables
  logic        irq_pending;            // Interrupt level from core
  logic [7:0]  special_out;            // Special output levels
  logic        rx_b_data;              // Channel B serial data
  logic        irq_out;                // Interrupt pin level
  logic        irq_oe_n;               // Interrupt pin enable
  dhp_route_type route;                // Routing toward core
  logic        rx_b_bit_valid;         // Sampled bit strobe
  logic        rx_b_bit;               // Sampled bit
  logic        ct_start;               // Counter start pulse
  logic        ct_stop;                // Counter stop pulse
  logic [7:0]  n_start, n_stop, n_rxv; // Event counters
  logic [7:0]  n_bad_oe;               // Port drove during a write
  logic [7:0]  q;                      // Last read byte
  int          bad_count;              // Mismatches
  int          checks_done;            // Comparisons made

  // The port wins the bus only while it enables its drivers
  assign data_bus = data_oe_n ? cpu_data : data_out;

  dhp_cpu_model u_cpu (.clk_sys(clk_sys), .bus(cpu_bus), .data_in(cpu_data),
    .data_out(data_out), .data_oe_n(data_oe_n));

  dhp_host_port u_dut (.clk_sys(clk_sys), .rst(rst), .bus(cpu_bus), .data_in(data_bus),
    .data_out(data_out), .data_oe_n(data_oe_n), .in_port(in_port), .out_port(out_port),
    .out_port_oe_n(out_port_oe_n), .irq_pending(irq_pending), .special_out(special_out),
    .rx_b_data(rx_b_data), .irq_out(irq_out), .irq_oe_n(irq_oe_n), .route(route),
    .rx_b_bit_valid(rx_b_bit_valid), .rx_b_bit(rx_b_bit), .ct_start(ct_start),
    .ct_stop(ct_stop));

  // Clock at 50 MHz
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // Event counters; counting beats sampling a one-cycle pulse by hand
  always @(posedge clk_sys) begin
    if (rst) begin
      n_start <= 8'h00;
      n_stop <= 8'h00;
      n_rxv <= 8'h00;
      n_bad_oe <= 8'h00;
    end else begin
      n_start <= n_start + {7'h00, ct_start};
      n_stop <= n_stop + {7'h00, ct_stop};
      n_rxv <= n_rxv + {7'h00, rx_b_bit_valid};
      n_bad_oe <= n_bad_oe + {7'h00, (!data_oe_n && !cpu_bus.wr_n)};
    end
  end

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask

  task automatic tally_and_finish();
    if (bad_count == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Watchdog, well past the expected run of a few hundred cycles
  initial begin
    #(20 * 20000);
    bad_count++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    bad_count = 0;
    checks_done = 0;
    rst = 1'b1;
    in_port = 7'h7f;
    irq_pending = 1'b0;
    special_out = 8'h00;
    rx_b_data = 1'b1;
    repeat (20) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk_bit(data_oe_n, 1'b1);
    chk_bit(irq_oe_n, 1'b1);
    // Vector register is plain storage
    u_cpu.rd(RD_VECTOR, q, 0);
    chk_byte(q, VECTOR_RST);
    u_cpu.wr(WR_VECTOR, 8'ha5, 0);
    u_cpu.wr(WR_VECTOR, 8'h11, 1);
    u_cpu.wr(WR_VECTOR, 8'h22, 2);
    u_cpu.rd(RD_VECTOR, q, 0);
    chk_byte(q, 8'ha5);
    u_cpu.wr(WR_VECTOR, 8'h5a, 3);
    u_cpu.rd(RD_VECTOR, q, 1);
    chk_byte(q, 8'h5a);
    // Plain stores read back at their own read addresses
    u_cpu.wr(WR_MODE_A, 8'hc3, 0);
    u_cpu.wr(WR_CSR_A, 8'h66, 0);
    u_cpu.wr(WR_MODE_B, 8'h99, 0);
    u_cpu.rd(RD_MODE_A, q, 0);
    chk_byte(q, 8'hc3);
    u_cpu.rd(RD_CSR_A, q, 0);
    chk_byte(q, 8'h66);
    u_cpu.rd(RD_MODE_B, q, 0);
    chk_byte(q, 8'h99);
    // A read address owned by the core returns zero here
    u_cpu.rd(4'h1, q, 0);
    chk_byte(q, 8'h00);
    // A lone strobe or select neither drives nor commands
    u_cpu.rd(RD_CT_START, q, 2);
    chk_byte(q, 8'hxx);
    u_cpu.rd(RD_CT_START, q, 3);
    chk_byte(q, 8'hxx);
    u_cpu.rd(RD_CT_START, q, 0);
    u_cpu.rd(RD_CT_STOP, q, 0);
    chk_byte({n_start[3:0], n_stop[3:0]}, 8'h11);
    // Output bits set and cleared by address
    u_cpu.wr(WR_OP_SET, 8'h3c, 0);
    u_cpu.wr(WR_OP_CLR, 8'h04, 0);
    chk_byte(out_port, 8'h38);
    chk_byte(out_port_oe_n, 8'h00);
    // Bit three turned open drain for a special function
    u_cpu.wr(WR_OPCR, 8'h08, 0);
    chk_bit(out_port[3], 1'b0);
    chk_bit(out_port_oe_n[3], 1'b0);
    special_out = 8'h08;
    repeat (3) @(negedge clk_sys);
    chk_bit(out_port_oe_n[3], 1'b1);
    irq_pending = 1'b1;
    repeat (3) @(negedge clk_sys);
    chk_byte({6'h00, irq_out, irq_oe_n}, 8'h00);
    // Input port read
    in_port = 7'h55;
    u_cpu.rd(RD_IN_PORT, q, 0);
    chk_byte({1'b0, q[6:0]}, 8'h55);
    // Change flags show the bits moved since the last read, then clear
    u_cpu.rd(RD_IPCR, q, 0);
    chk_byte(q, 8'h2a);
    u_cpu.rd(RD_IPCR, q, 0);
    chk_byte(q, 8'h00);
    // Receiver B clocked from input six, sampling on rising edges
    u_cpu.wr(WR_CSR_B, 8'hf0, 0);
    chk_bit(route.rx_b_ext_sel, 1'b1);
    u_cpu.rd(RD_CSR_B, q, 0);
    chk_byte(q, 8'hf0);
    for (int i = 0; i < 4; i++) begin
      rx_b_data = i[0];
      in_port = 7'h00;
      repeat (5) @(negedge clk_sys);
      in_port = 7'h40;
      repeat (5) @(negedge clk_sys);
      chk_byte({route.chan_b_rx_ext_clock, rx_b_bit}, {1'b1, i[0]});
    end
    // Input two toggling never clocks receiver B
    in_port = 7'h44;
    repeat (5) @(negedge clk_sys);
    in_port = 7'h40;
    repeat (5) @(negedge clk_sys);
    chk_byte(n_rxv, 8'h04);
    u_cpu.wr(WR_CSR_B, 8'he0, 0);
    chk_bit(route.rx_b_ext_sel, 1'b0);
    // Timer source over every mode value
    for (int i = 0; i < 8; i++) begin
      u_cpu.wr(WR_ACR, {1'b0, i[2:0], 4'h0}, 0);
      chk_bit(route.ct_ext_sel, (i[2:0] == CT_SRC_IP2) || (i[2:0] == CNT_SRC_IP2));
    end
    in_port = 7'h04;
    repeat (5) @(negedge clk_sys);
    chk_bit(route.ct_ext_clock, 1'b1);
    chk_byte(n_bad_oe, 8'h00);
    // Second reset in mid-run
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    rst = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk_byte(out_port, BYTE_RST);
    u_cpu.rd(RD_VECTOR, q, 0);
    chk_byte(q, VECTOR_RST);
    tally_and_finish();
  end
endmodule // duart_generic_host_port_tb_top
`default_nettype wire
